// File: tki_host.sv
// Host (bus controller) end of the touch-key two-wire port.
// Assumes one command at a time; SCL is made by a divider of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tki_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial lines
   tki_link_if.host link,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] cmd_len,
   // Answer
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic done,
   output logic nacked
);

   typedef struct packed {
      tki_pkg::tki_hst_t st;
      tki_pkg::tki_step_t step;
      logic [1:0] ph;
      logic [tki_pkg::QTR_W-1:0] tq;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic ackb;
      logic rd;
      logic [7:0] maddr;
      logic [7:0] wdata;
      logic [7:0] left;
      logic scl_low;
      logic sda_low;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic done;
      logic nacked;
   } tki_hreg_t;

   tki_hreg_t h_q;
   tki_hreg_t h_d;
   logic [1:0] lsync;
   logic scl_s;
   logic sda_s;
   logic tick;
   logic adv;

   tki_sync #(.W(2)) u_sync (
      .clk(ref_clk),
      .d({link.scl, link.sda}),
      .q(lsync)
   );

   assign scl_s = lsync[1];
   assign sda_s = lsync[0];

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] byte_of(input tki_pkg::tki_step_t s, input logic [7:0] a,
      input logic [7:0] w);
      case (s)
         tki_pkg::S_DEVW: byte_of = {tki_pkg::TGT_ADDR, tki_pkg::DIR_WRITE};
         tki_pkg::S_MEM: byte_of = a;
         tki_pkg::S_DATA: byte_of = w;
         tki_pkg::S_DEVR: byte_of = {tki_pkg::TGT_ADDR, tki_pkg::DIR_READ};
         default: byte_of = '0;
      endcase
   endfunction

   // Whether to pull SDA low for bit n of a byte
   function automatic logic pull_for(input logic [3:0] n, input logic [7:0] b,
      input tki_pkg::tki_step_t s, input logic [7:0] lft);
      if (s != tki_pkg::S_RDATA) begin
         pull_for = (n != tki_pkg::BITS_PER_BYTE) && !b[tki_pkg::BYTE_MSB];
      end else begin
         // NACK last byte
         // NACK only the last byte read
         pull_for = (n == tki_pkg::BITS_PER_BYTE) && (lft != tki_pkg::READ_LEN_MIN);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   // quarter-bit pacing
   assign tick = (h_q.tq == tki_pkg::QTR_LAST);
   // wait for clock high
   // A released clock counts only once it is seen high, so stretching holds us
   assign adv = tick && (h_q.ph != tki_pkg::PH_RISE || scl_s);

   always_comb begin
      tki_pkg::tki_step_t ns;
      logic stop_now;
      logic [7:0] nb;
      ns = h_q.step;
      stop_now = 1'b0;
      nb = '0;
      h_d = h_q;
      h_d.rsp_valid = 1'b0;
      h_d.done = 1'b0;
      if (h_q.st == tki_pkg::H_IDLE || adv) begin
         h_d.tq = '0;
      end else if (!tick) begin
         h_d.tq = h_q.tq + 1'b1;
      end
      if (adv) begin
         h_d.ph = h_q.ph + 2'h1;
      end
      case (h_q.st)
         tki_pkg::H_IDLE: begin
            h_d.ph = tki_pkg::PH_SET;
            if (cmd_valid) begin
               h_d.rd = cmd_read;
               h_d.maddr = cmd_addr;
               h_d.wdata = cmd_wdata;
               h_d.left = (cmd_len == '0) ? tki_pkg::READ_LEN_MIN : cmd_len;
               h_d.step = tki_pkg::S_DEVW;
               h_d.nacked = 1'b0;
               h_d.st = tki_pkg::H_START;
            end
         end
         tki_pkg::H_START: begin
            if (adv) begin
               case (h_q.ph)
                  tki_pkg::PH_SET: h_d.scl_low = 1'b0;
                  tki_pkg::PH_RISE: h_d.sda_low = 1'b1;
                  tki_pkg::PH_HIGH: h_d.scl_low = 1'b1;
                  default: begin
                     nb = byte_of(h_q.step, h_q.maddr, h_q.wdata);
                     h_d.st = tki_pkg::H_BIT;
                     h_d.bcnt = '0;
                     h_d.sh = nb;
                     h_d.sda_low = pull_for('0, nb, h_q.step, h_q.left);
                  end
               endcase
            end
         end
         tki_pkg::H_BIT: begin
            if (adv) begin
               case (h_q.ph)
                  tki_pkg::PH_SET: h_d.scl_low = 1'b0;
                  tki_pkg::PH_RISE: begin
                     if (h_q.bcnt != tki_pkg::BITS_PER_BYTE) begin
                        h_d.sh = {h_q.sh[tki_pkg::BYTE_MSB-1:0], sda_s};
                     end else begin
                        h_d.ackb = sda_s;
                     end
                  end
                  tki_pkg::PH_HIGH: h_d.scl_low = 1'b1;
                  default: begin
                     if (h_q.bcnt != tki_pkg::BITS_PER_BYTE) begin
                        h_d.bcnt = h_q.bcnt + 4'h1;
                        h_d.sda_low = pull_for(h_d.bcnt, h_q.sh, h_q.step, h_q.left);
                     end else begin
                        if (h_q.step == tki_pkg::S_RDATA) begin
                           h_d.rsp_valid = 1'b1;
                           h_d.rsp_data = h_q.sh;
                           h_d.left = h_q.left - 8'h01;
                           stop_now = (h_q.left == tki_pkg::READ_LEN_MIN);
                        end else if (h_q.ackb) begin
                           h_d.nacked = 1'b1;
                           stop_now = 1'b1;
                        end else begin
                           case (h_q.step)
                              tki_pkg::S_DEVW: ns = tki_pkg::S_MEM;
                              tki_pkg::S_MEM: ns = h_q.rd ? tki_pkg::S_DEVR : tki_pkg::S_DATA;
                              tki_pkg::S_DEVR: ns = tki_pkg::S_RDATA;
                              default: stop_now = 1'b1;
                           endcase
                        end
                        h_d.step = ns;
                        nb = byte_of(ns, h_q.maddr, h_q.wdata);
                        if (stop_now) begin
                           h_d.st = tki_pkg::H_STOP;
                           h_d.sda_low = 1'b1;
                        end else if (ns == tki_pkg::S_DEVR && h_q.step == tki_pkg::S_MEM) begin
                           // repeated start first
                           // Repeated start before the read address
                           h_d.st = tki_pkg::H_START;
                           h_d.sda_low = 1'b0;
                        end else begin
                           h_d.bcnt = '0;
                           h_d.sh = nb;
                           h_d.sda_low = pull_for('0, nb, ns, h_d.left);
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            if (adv) begin
               case (h_q.ph)
                  tki_pkg::PH_SET: h_d.scl_low = 1'b0;
                  tki_pkg::PH_RISE: h_d.sda_low = 1'b0;
                  tki_pkg::PH_HIGH: begin
                  end
                  default: begin
                     h_d.done = 1'b1;
                     h_d.st = tki_pkg::H_IDLE;
                  end
               endcase
            end
         end
      endcase
      if (!rst_n) begin
         h_d = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      h_q <= h_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign cmd_ready = (h_q.st == tki_pkg::H_IDLE);
   assign rsp_valid = h_q.rsp_valid;
   assign rsp_data = h_q.rsp_data;
   assign done = h_q.done;
   assign nacked = h_q.nacked;
   assign link.h_scl_o = tki_pkg::LINE_LOW;
   assign link.h_scl_oe = h_q.scl_low;
   assign link.h_sda_o = tki_pkg::LINE_LOW;
   assign link.h_sda_oe = h_q.sda_low;

endmodule
`default_nettype wire

// File: tki_link_if.sv
// Two-wire link between the host end and the target end.
// Assumes external pull-ups: a line is low only while some party drives it low.
`timescale 1ns/1ps
`default_nettype none
interface tki_link_if;
   logic scl;
   logic sda;
   logic d_scl_o;
   logic d_scl_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic h_scl_o;
   logic h_scl_oe;
   logic h_sda_o;
   logic h_sda_oe;

   // Wired-AND with pull-up
   assign scl = ~((d_scl_oe & ~d_scl_o) | (h_scl_oe & ~h_scl_o));
   assign sda = ~((d_sda_oe & ~d_sda_o) | (h_sda_oe & ~h_sda_o));

   modport dev (input scl, input sda, output d_scl_o, output d_scl_oe, output d_sda_o,
      output d_sda_oe);
   modport host (input scl, input sda, output h_scl_o, output h_scl_oe, output h_sda_o,
      output h_sda_oe);
endinterface
`default_nettype wire

// File: tki_link_props.sv
// Link checker: open drain, start/stop order, acknowledge and stretch timing.
// Assumes it sits beside the link interface; everything sampled on link_clk.
`timescale 1ns/1ps
`default_nettype none
module tki_link_props (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   // Link lines and drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic d_scl_o,
   input wire logic d_scl_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic h_scl_o,
   input wire logic h_scl_oe,
   input wire logic h_sda_o,
   input wire logic h_sda_oe
);
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!rst_n);
   logic [5:0] hold_q;
   logic [5:0] hold_d;
   // Saturating count of cycles the target holds the clock low
   always_comb begin
      hold_d = d_scl_oe ? hold_q + {5'h00, hold_q != 6'h3F} : 6'h00;
   end
   always_ff @(posedge link_clk) begin
      hold_q <= rst_n ? hold_d : 6'h00;
   end
   sequence start_seq;
      scl && $fell(sda);
   endsequence
   sequence stop_seq;
      scl && $rose(sda);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_open_drain:
      assert property (!d_scl_o && !d_sda_o && !h_scl_o && !h_sda_o) else $error("line driven high");
   a_ack_hold:
      assert property ($rose(d_sda_oe) |-> d_sda_oe [*8]) else $error("target low too short");
   a_no_bus_cond:
      assert property (scl && $past(scl) |-> $stable(d_sda_oe)) else $error("target moved sda");
   a_sda_clk_low:
      assert property ($rose(d_sda_oe) |-> !scl) else $error("target pulled sda with clock high");
   a_stretch_low:
      assert property ($rose(d_scl_oe) |-> !scl) else $error("stretch began with clock high");
   a_stretch_bound:
      assert property (hold_q < 6'h20) else $error("clock stretch too long");
   a_start_order:
      assert property (start_seq |=> scl [*2]) else $error("start without clock high");
   a_stop_order:
      assert property (stop_seq |-> $past(scl, 2)) else $error("stop without clock high");
endmodule
`default_nettype wire

// File: tki_pkg.sv
// Shared constants, types and helpers for the touch-key two-wire target port.
// Assumes both ends and the testbench compile this package first.
package tki_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned BIT_RATE_BPS = 400_000;
   // Fastest legal rate gives the shortest quarter bit, so round up
   localparam int unsigned QTR_CYC = (CLK_HZ + 4 * BIT_RATE_BPS - 1) / (4 * BIT_RATE_BPS);
   localparam int QTR_W = 8;
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Byte layout and addressing
   localparam int BYTE_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] TGT_ADDR = 7'h30;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [7:0] MEM_ADDR_MIN = 8'h00;
   localparam logic [7:0] MEM_ADDR_MAX = 8'h4F;
   localparam logic [7:0] READ_LEN_MIN = 8'h01;
   localparam logic LINE_LOW = 1'b0;

   // Host bit phases, one quarter bit each
   localparam logic [1:0] PH_SET = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // State types
   typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_FETCH, L_TX, L_RACK, L_WAIT} tki_lst_t;
   typedef enum logic [1:0] {K_ADDR, K_MEM, K_WDATA} tki_kind_t;
   typedef enum logic {R_IDLE, R_ACCESS} tki_rst_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tki_hst_t;
   typedef enum logic [2:0] {S_DEVW, S_MEM, S_DATA, S_DEVR, S_RDATA} tki_step_t;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic tki_addr_match(input logic [7:0] b);
      return b[BYTE_MSB:ADDR_LSB] == TGT_ADDR;
   endfunction

   // Sequential reads wrap back to the bottom of the map
   function automatic logic [7:0] tki_next_addr(input logic [7:0] a);
      return (a >= MEM_ADDR_MAX) ? MEM_ADDR_MIN : a + 8'h01;
   endfunction

endpackage

// File: tki_sync.sv
// Two-flop synchroniser for levels and toggles.
// Assumes each bit is independent or held stable by a handshake.
`timescale 1ns/1ps
`default_nettype none
module tki_sync #(
   parameter int W = 1
) (
   // Destination clock
   input wire logic clk,
   // Asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } tki_sync_st_t;

   tki_sync_st_t s_q;
   tki_sync_st_t s_d;

   always_comb begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign q = s_q.s2;
endmodule
`default_nettype wire

// File: tki_target.sv
// Target end of the touch-key two-wire port: serial logic on link_clk,
// register-space port on ref_clk.
// Assumes mem_rdata is a combinational function of mem_addr.
//
// What this block does
// - Works at bit rates up to 400 kbit/s.
// - Target only; never starts traffic itself.
// - Byte write, random read, continuous read only.
// - Write is device address, memory address, data.
// - Idle bus leaves both lines high.
// - Host starts: data low, then clock low.
// - Capture received bits on clock rising edge.
// - Acknowledge each received byte low on ninth clock, except another device's address or a memory address above 0x4F.
// - Host stops: clock high, then data high.
// - Read is address, memory, address-read, data.
// - Host repeats start before the read address.
// - Stretch clock low until read byte ready.
// - Host waits for clock high before reading.
// - Host NACKs the single random-read byte.
// - Keep sending bytes while host acknowledges.
// - Advance memory address after each byte sent.
// - Lines are open drain, low or released.
// - Memory addresses span zero through 0x4F.
`timescale 1ns/1ps
`default_nettype none
module tki_target (
   // System side clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link sampling clock
   input wire logic link_clk,
   // Serial lines
   tki_link_if.dev link,
   // Register space port
   output logic [7:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   input wire logic [7:0] mem_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      tki_pkg::tki_lst_t st;
      tki_pkg::tki_lst_t nxt;
      tki_pkg::tki_kind_t kind;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] maddr;
      logic scl_p;
      logic sda_p;
      logic sda_low;
      logic scl_low;
      logic req_tgl;
      logic req_wr;
      logic [7:0] req_addr;
      logic [7:0] req_wdata;
      logic ack_seen;
   } tki_lnk_t;

   typedef struct packed {
      tki_pkg::tki_rst_t st;
      logic req_seen;
      logic [7:0] mem_addr;
      logic [7:0] mem_wdata;
      logic mem_we;
      logic [7:0] rdata;
      logic ack_tgl;
   } tki_ref_t;

   tki_lnk_t l_q;
   tki_lnk_t l_d;
   tki_ref_t r_q;
   tki_ref_t r_d;

   logic [3:0] lsync;
   logic lrst_n;
   logic scl_s;
   logic sda_s;
   logic ack_s;
   logic req_s;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;

   ////////////////////////////////////////////////////////////////////////////
   // Crossings
   // synchronise lines
   tki_sync #(.W(4)) u_lsync (
      .clk(link_clk),
      .d({rst_n, link.scl, link.sda, r_q.ack_tgl}),
      .q(lsync)
   );

   tki_sync #(.W(1)) u_rsync (
      .clk(ref_clk),
      .d(l_q.req_tgl),
      .q(req_s)
   );

   assign lrst_n = lsync[3];
   assign scl_s = lsync[2];
   assign sda_s = lsync[1];
   assign ack_s = lsync[0];

   assign rise = scl_s & ~l_q.scl_p;
   assign fall = ~scl_s & l_q.scl_p;
   assign start_c = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
   assign stop_c = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // Link-side sequencing
   always_comb begin
      l_d = l_q;
      l_d.scl_p = scl_s;
      l_d.sda_p = sda_s;
      case (l_q.st)
         tki_pkg::L_RX: begin
            if (rise) begin
               l_d.sh = {l_q.sh[tki_pkg::BYTE_MSB-1:0], sda_s};
               l_d.cnt = l_q.cnt + 4'h1;
            end else if (fall && l_q.cnt == tki_pkg::BITS_PER_BYTE) begin
               l_d.cnt = '0;
               l_d.st = tki_pkg::L_ACK;
               l_d.sda_low = 1'b1;
               case (l_q.kind)
                  tki_pkg::K_ADDR: begin
                     if (tki_pkg::tki_addr_match(l_q.sh)) begin
                        if (l_q.sh[0] == tki_pkg::DIR_READ) begin
                           l_d.nxt = tki_pkg::L_FETCH;
                        end else begin
                           l_d.nxt = tki_pkg::L_RX;
                        end
                        l_d.kind = tki_pkg::K_MEM;
                     end else begin
                        l_d.st = tki_pkg::L_WAIT;
                        l_d.sda_low = 1'b0;
                     end
                  end
                  tki_pkg::K_MEM: begin
                     if (l_q.sh <= tki_pkg::MEM_ADDR_MAX) begin
                        l_d.maddr = l_q.sh;
                        l_d.nxt = tki_pkg::L_RX;
                        l_d.kind = tki_pkg::K_WDATA;
                     end else begin
                        l_d.st = tki_pkg::L_WAIT;
                        l_d.sda_low = 1'b0;
                     end
                  end
                  default: begin
                     l_d.nxt = tki_pkg::L_WAIT;
                     l_d.req_wr = 1'b1;
                     l_d.req_addr = l_q.maddr;
                     l_d.req_wdata = l_q.sh;
                     l_d.req_tgl = ~l_q.req_tgl;
                  end
               endcase
            end
         end
         tki_pkg::L_ACK: begin
            if (fall) begin
               l_d.sda_low = 1'b0;
               l_d.st = l_q.nxt;
               if (l_q.nxt == tki_pkg::L_FETCH) begin
                  l_d.scl_low = 1'b1;
                  l_d.req_wr = 1'b0;
                  l_d.req_addr = l_q.maddr;
                  l_d.req_tgl = ~l_q.req_tgl;
               end
            end
         end
         tki_pkg::L_FETCH: begin
            if (ack_s != l_q.ack_seen) begin
               // Data is set up one cycle before the clock is let go
               l_d.ack_seen = ack_s;
               l_d.sh = r_q.rdata;
               l_d.sda_low = ~r_q.rdata[tki_pkg::BYTE_MSB];
               l_d.cnt = '0;
               l_d.st = tki_pkg::L_TX;
            end
         end
         tki_pkg::L_TX: begin
            if (l_q.scl_low) begin
               l_d.scl_low = 1'b0;
            end else if (rise) begin
               l_d.cnt = l_q.cnt + 4'h1;
            end else if (fall) begin
               if (l_q.cnt == tki_pkg::BITS_PER_BYTE) begin
                  l_d.sda_low = 1'b0;
                  l_d.st = tki_pkg::L_RACK;
               end else begin
                  l_d.sh = {l_q.sh[tki_pkg::BYTE_MSB-1:0], 1'b0};
                  l_d.sda_low = ~l_q.sh[tki_pkg::BYTE_MSB-1];
               end
            end
         end
         tki_pkg::L_RACK: begin
            if (rise) begin
               l_d.maddr = tki_pkg::tki_next_addr(l_q.maddr);
               if (sda_s) begin
                  l_d.st = tki_pkg::L_WAIT;
               end else begin
                  l_d.st = tki_pkg::L_ACK;
                  l_d.nxt = tki_pkg::L_FETCH;
               end
            end
         end
         default: begin
         end
      endcase
      if (stop_c) begin
         l_d.st = tki_pkg::L_IDLE;
         l_d.sda_low = 1'b0;
         l_d.scl_low = 1'b0;
      end else if (start_c) begin
         l_d.st = tki_pkg::L_RX;
         l_d.kind = tki_pkg::K_ADDR;
         l_d.cnt = '0;
         l_d.sda_low = 1'b0;
         l_d.scl_low = 1'b0;
      end
      if (!lrst_n) begin
         l_d = '0;
         l_d.scl_p = 1'b1;
         l_d.sda_p = 1'b1;
         l_d.ack_seen = ack_s;
      end
   end

   always_ff @(posedge link_clk) begin
      l_q <= l_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register-space side
   always_comb begin
      r_d = r_q;
      r_d.mem_we = 1'b0;
      case (r_q.st)
         tki_pkg::R_IDLE: begin
            if (req_s != r_q.req_seen) begin
               // Request words are held by the link side until answered
               r_d.req_seen = req_s;
               r_d.mem_addr = l_q.req_addr;
               r_d.mem_wdata = l_q.req_wdata;
               r_d.st = tki_pkg::R_ACCESS;
            end
         end
         default: begin
            if (l_q.req_wr) begin
               r_d.mem_we = 1'b1;
            end else begin
               r_d.rdata = mem_rdata;
               r_d.ack_tgl = ~r_q.ack_tgl;
            end
            r_d.st = tki_pkg::R_IDLE;
         end
      endcase
      if (!rst_n) begin
         r_d = '0;
         r_d.req_seen = req_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      r_q <= r_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // open-drain drive
   assign link.d_scl_o = tki_pkg::LINE_LOW;
   assign link.d_scl_oe = l_q.scl_low;
   assign link.d_sda_o = tki_pkg::LINE_LOW;
   assign link.d_sda_oe = l_q.sda_low;
   assign mem_addr = r_q.mem_addr;
   assign mem_wdata = r_q.mem_wdata;
   assign mem_we = r_q.mem_we;

endmodule
`default_nettype wire

// File: touch_key_i2c_target_port_test.sv
// Testbench: host end and target end joined by the link, register space modelled here.
// Assumes the package and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module touch_key_i2c_target_port_test;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, cmd_len = 8'h01;
   logic cmd_ready, rsp_valid, done, nacked, mem_we;
   logic [7:0] rsp_data, mem_addr, mem_wdata;
   logic [7:0] mem [0:79];
   logic [7:0] got [$];
   int errors = 0, check_count = 0, we_count = 0;
   wire logic [7:0] mem_rdata = (mem_addr <= 8'h4F) ? mem[mem_addr] : 8'h00;
   tki_link_if link ();
   always #2.5 ref_clk = ~ref_clk;
   always #24 link_clk = ~link_clk;
   always @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
         we_count <= we_count + 1;
      end
   end
   tki_target tki_target_inst (.ref_clk, .rst_n, .link_clk, .link(link.dev), .mem_addr,
      .mem_wdata, .mem_we, .mem_rdata);
   tki_host tki_host_inst (.ref_clk, .rst_n, .link(link.host), .cmd_valid, .cmd_ready,
      .cmd_read, .cmd_addr, .cmd_wdata, .cmd_len, .rsp_valid, .rsp_data, .done, .nacked);
   tki_link_props tki_link_props_inst (.ref_clk, .rst_n, .link_clk, .scl(link.scl),
      .sda(link.sda), .d_scl_o(link.d_scl_o), .d_scl_oe(link.d_scl_oe),
      .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .h_scl_o(link.h_scl_o),
      .h_scl_oe(link.h_scl_oe), .h_sda_o(link.h_sda_o), .h_sda_oe(link.h_sda_oe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One command through the host; read bytes collected until done
   task automatic run(input logic rd, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] n);
      int i;
      got.delete();
      @(posedge ref_clk);
      #1;
      check("ready idle", {7'h00, cmd_ready}, 8'h01);
      cmd_read = rd;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_len = n;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      check("ready busy", {7'h00, cmd_ready}, 8'h00);
      for (i = 0; i < 40000 && done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
         if (rsp_valid === 1'b1) begin
            got.push_back(rsp_data);
         end
      end
      if (i == 40000) begin
         errors++;
         wrap_up();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      run(1'b0, 8'h4F, 8'hA5, 8'h01);
      check("write strobes", 8'(we_count), 8'h01);
      check("stored byte", mem[79], 8'hA5);
      check("write nack", {7'h00, nacked}, 8'h00);
      $display("byte write at top address done");
   endtask
   task automatic t_rand_read();
      run(1'b1, 8'h4F, 8'h00, 8'h01);
      check("read count", 8'(got.size()), 8'h01);
      check("read byte", got[0], 8'hA5);
      check("read strobes", 8'(we_count), 8'h01);
      $display("random read done");
   endtask
   task automatic t_cont_read();
      run(1'b1, 8'h4E, 8'h00, 8'h03);
      check("burst count", 8'(got.size()), 8'h03);
      check("burst 0", got[0], 8'h5F);
      check("burst 1", got[1], 8'hA5);
      check("burst wrap", got[2], 8'h11);
      $display("continuous read done");
   endtask
   task automatic t_bad_addr();
      run(1'b0, 8'h50, 8'h77, 8'h01);
      check("range nack", {7'h00, nacked}, 8'h01);
      check("range strobes", 8'(we_count), 8'h01);
      $display("out of range write refused");
   endtask
   initial begin
      for (int k = 0; k < 80; k++) begin
         mem[k] = 8'(k) + 8'h11;
      end
      // Long enough for four link clock edges as well
      repeat (40) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (40) @(posedge ref_clk);
      t_write();
      t_rand_read();
      t_cont_read();
      t_bad_addr();
      wrap_up();
   end
endmodule
`default_nettype wire
